// file: logic/pcie_cap_pkg.sv
// Constants shared by the capability register bank and its helpers
package pcie_cap_pkg;
	// Register offsets in configuration space
	localparam logic [7:0] CAP_OFFSET = 8'h92;
	localparam logic [7:0] DEVCAP_OFFSET = 8'h94;
	localparam int CFG_ADDR_W = 8;
	localparam int CFG_DATA_W = 32;

	// Capabilities register fields
	localparam int CAP_RSVD_HI = 15;
	localparam int CAP_RSVD_LO = 9;
	localparam int CAP_SLOT_POS = 8;
	localparam int CAP_TYPE_HI = 7;
	localparam int CAP_TYPE_LO = 4;
	localparam int CAP_VER_HI = 3;
	localparam int CAP_VER_LO = 0;
	localparam logic [3:0] PORT_TYPE_BRIDGE = 4'h7;
	localparam logic [3:0] CAP_VERSION = 4'h1;
	localparam logic [15:0] CAP_RESET = 16'h0071;

	// Device capabilities register fields
	localparam int DC_RSVD_HI = 31;
	localparam int DC_RSVD_LO = 28;
	localparam int DC_RSVD_MID_HI = 17;
	localparam int DC_RSVD_MID_LO = 16;
	localparam int DC_SCALE_HI = 27;
	localparam int DC_SCALE_LO = 26;
	localparam int DC_VALUE_HI = 25;
	localparam int DC_VALUE_LO = 18;
	localparam int DC_ROLE_BASED_ERR_FLAG_POS = 15;
	localparam int DC_PIND_POS = 14;
	localparam int DC_AIND_POS = 13;
	localparam int DC_ABTN_POS = 12;
	localparam int DC_L1_HI = 11;
	localparam int DC_L1_LO = 9;
	localparam int DC_L0S_HI = 8;
	localparam int DC_L0S_LO = 6;
	localparam int DC_ETAG_POS = 5;
	localparam int DC_PFS_HI = 4;
	localparam int DC_PFS_LO = 3;
	localparam int DC_MPS_HI = 2;
	localparam int DC_MPS_LO = 0;
	localparam logic [2:0] MAX_PAYLOAD_512 = 3'h2;
	localparam logic [1:0] PHANTOM_NONE = 2'h0;
	localparam logic [31:0] DEVCAP_RESET = 32'h00008002;
	localparam logic [31:0] RDATA_RESET = 32'h00000000;

	// Slot power message payload layout
	localparam int MSG_PAYLOAD_W = 10;
	localparam int MSG_SCALE_HI = 9;
	localparam int MSG_SCALE_LO = 8;
	localparam int MSG_VALUE_HI = 7;
	localparam int MSG_VALUE_LO = 0;

	// Power scale multiplier codes
	typedef enum logic [1:0] {SCALE_X1, SCALE_X0P1, SCALE_X0P01, SCALE_X0P001} power_scale_e;

	// Latency fields and reset values for the latency, scale and value fields
	localparam int LAT_W = 3;
	localparam int LAT_KINDS = 2;
	localparam int LAT_L1 = 0;
	localparam int LAT_L0S = 1;
	localparam logic [2:0] LAT_RESET = 3'h0;
	localparam logic [1:0] SCALE_RESET = 2'h0;
	localparam logic [7:0] VALUE_RESET = 8'h00;
endpackage : pcie_cap_pkg

// file: logic/cap_fields_if.sv
// Fields passed from the helper modules to the register bank
`timescale 1ns/1ps
`default_nettype none
interface cap_fields_if;
	logic [1:0] scale;
	logic [7:0] value;
	logic [2:0] lat [pcie_cap_pkg::LAT_KINDS];

	modport capture (output scale, output value);
	modport clamp (output lat);
	modport bank (input scale, input value, input lat);
endinterface : cap_fields_if
`default_nettype wire

// file: logic/slot_power_capture.sv
// Holds the slot power limit captured from the latest message
`timescale 1ns/1ps
`default_nettype none
module slot_power_capture (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic msg_valid,
	input wire logic [pcie_cap_pkg::MSG_PAYLOAD_W-1:0] msg_payload,
	cap_fields_if.capture fields
);
	logic [1:0] scale;
	logic [7:0] value;
	logic [1:0] next_scale;
	logic [7:0] next_value;

	// Load on a message, otherwise hold the last one
	assign next_scale = msg_valid ?
		msg_payload[pcie_cap_pkg::MSG_SCALE_HI:pcie_cap_pkg::MSG_SCALE_LO] : scale;
	assign next_value = msg_valid ?
		msg_payload[pcie_cap_pkg::MSG_VALUE_HI:pcie_cap_pkg::MSG_VALUE_LO] : value;

	// Captured fields, cleared by reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scale <= pcie_cap_pkg::SCALE_RESET;
			value <= pcie_cap_pkg::VALUE_RESET;
		end else begin
			scale <= next_scale;
			value <= next_value;
		end
	end

	// Scale code passes through unchanged
	assign fields.scale = scale;
	assign fields.value = value;
endmodule : slot_power_capture
`default_nettype wire

// file: logic/latency_clamp.sv
// Reports a programmed acceptable latency, registered and raised to the exit latency when below it; zero in reset
`timescale 1ns/1ps
`default_nettype none
module latency_clamp #(
	parameter int IDX = 0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [pcie_cap_pkg::LAT_W-1:0] programmed,
	input wire logic [pcie_cap_pkg::LAT_W-1:0] exit_lat,
	cap_fields_if.clamp fields
);
	logic [pcie_cap_pkg::LAT_W-1:0] reported;
	logic [pcie_cap_pkg::LAT_W-1:0] next_reported;

	// Larger of programmed value and exit latency
	assign next_reported = (programmed < exit_lat) ? exit_lat : programmed;

	// Reported field, zero after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reported <= pcie_cap_pkg::LAT_RESET;
		end else begin
			reported <= next_reported;
		end
	end

	assign fields.lat[IDX] = reported;
endmodule : latency_clamp
`default_nettype wire

// file: logic/pcie_capability_regs.sv
// Read-only PCIe capability and device capability registers
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_regs (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CFG_RD,
	input wire logic CFG_WR,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [31:0] CFG_WDATA,
	input wire logic MSG_SLOT_PWR_VALID,
	input wire logic [9:0] MSG_SLOT_PWR_PAYLOAD,
	input wire logic [2:0] GEN_GEN_CTRL_A,
	input wire logic [2:0] GEN_GEN_CTRL_B,
	input wire logic [2:0] PHY_L1_EXIT_LAT,
	input wire logic [2:0] PHY_L0S_EXIT_LAT,
	output logic [31:0] CFG_RDATA,
	output logic CFG_RD_ACK,
	output logic CFG_WR_ACK,
	output logic CFG_HIT,
	output logic [15:0] CAP_VALUE,
	output logic [31:0] DEVCAP_VALUE
);
	// Which register an address selects
	typedef enum {SEL_NONE, SEL_CAP, SEL_DEVCAP} reg_sel_e;

	// Address decode shared by reads and writes
	function automatic reg_sel_e decode(input logic [7:0] addr);
		reg_sel_e sel;
		sel = SEL_NONE;
		case (addr)
			pcie_cap_pkg::CAP_OFFSET: begin
				sel = SEL_CAP;
			end
			pcie_cap_pkg::DEVCAP_OFFSET: begin
				sel = SEL_DEVCAP;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
		return sel;
	endfunction : decode

	cap_fields_if fields ();

	logic [2:0] programmed [pcie_cap_pkg::LAT_KINDS];
	logic [2:0] exit_lat [pcie_cap_pkg::LAT_KINDS];
	logic [15:0] cap_word;
	logic [31:0] devcap_word;
	reg_sel_e rd_sel;
	reg_sel_e wr_sel;
	logic rd_hit;
	logic wr_hit;
	logic [31:0] next_rdata;
	logic [31:0] rdata;
	logic rd_ack;
	logic wr_ack;
	logic hit;
	logic [15:0] cap_q;
	logic [31:0] devcap_q;

	// Captured slot power limit from messages
	slot_power_capture u_capture (
		.clk(CLK),
		.rst_b(RST_B),
		.msg_valid(MSG_SLOT_PWR_VALID),
		.msg_payload(MSG_SLOT_PWR_PAYLOAD),
		.fields(fields.capture)
	);

	// Mirrored control fields and PHY exit latencies per state
	assign programmed[pcie_cap_pkg::LAT_L1] = GEN_GEN_CTRL_A;
	assign programmed[pcie_cap_pkg::LAT_L0S] = GEN_GEN_CTRL_B;
	assign exit_lat[pcie_cap_pkg::LAT_L1] = PHY_L1_EXIT_LAT;
	assign exit_lat[pcie_cap_pkg::LAT_L0S] = PHY_L0S_EXIT_LAT;

	// One clamp per link state
	generate
		for (genvar k = 0; k < pcie_cap_pkg::LAT_KINDS; k++) begin : g_lat
			latency_clamp #(
				.IDX(k)
			) u_clamp (
				.clk(CLK),
				.rst_b(RST_B),
				.programmed(programmed[k]),
				.exit_lat(exit_lat[k]),
				.fields(fields.clamp)
			);
		end
	endgenerate

	// Capabilities word, fixed fields only
	assign cap_word[pcie_cap_pkg::CAP_RSVD_HI:pcie_cap_pkg::CAP_RSVD_LO] = 7'h00;
	assign cap_word[pcie_cap_pkg::CAP_SLOT_POS] = 1'b0;
	assign cap_word[pcie_cap_pkg::CAP_TYPE_HI:pcie_cap_pkg::CAP_TYPE_LO] =
		pcie_cap_pkg::PORT_TYPE_BRIDGE;
	assign cap_word[pcie_cap_pkg::CAP_VER_HI:pcie_cap_pkg::CAP_VER_LO] =
		pcie_cap_pkg::CAP_VERSION;

	// Device capabilities word: reserved and hardwired bits
	assign devcap_word[pcie_cap_pkg::DC_RSVD_HI:pcie_cap_pkg::DC_RSVD_LO] = 4'h0;
	assign devcap_word[pcie_cap_pkg::DC_RSVD_MID_HI:pcie_cap_pkg::DC_RSVD_MID_LO] = 2'h0;
	assign devcap_word[pcie_cap_pkg::DC_ROLE_BASED_ERR_FLAG_POS] = 1'b1;
	assign devcap_word[pcie_cap_pkg::DC_PIND_POS] = 1'b0;
	assign devcap_word[pcie_cap_pkg::DC_AIND_POS] = 1'b0;
	assign devcap_word[pcie_cap_pkg::DC_ABTN_POS] = 1'b0;
	assign devcap_word[pcie_cap_pkg::DC_ETAG_POS] = 1'b0;
	assign devcap_word[pcie_cap_pkg::DC_PFS_HI:pcie_cap_pkg::DC_PFS_LO] =
		pcie_cap_pkg::PHANTOM_NONE;
	assign devcap_word[pcie_cap_pkg::DC_MPS_HI:pcie_cap_pkg::DC_MPS_LO] =
		pcie_cap_pkg::MAX_PAYLOAD_512;

	// Device capabilities word: captured and mirrored fields
	assign devcap_word[pcie_cap_pkg::DC_SCALE_HI:pcie_cap_pkg::DC_SCALE_LO] =
		fields.scale;
	assign devcap_word[pcie_cap_pkg::DC_VALUE_HI:pcie_cap_pkg::DC_VALUE_LO] =
		fields.value;
	assign devcap_word[pcie_cap_pkg::DC_L1_HI:pcie_cap_pkg::DC_L1_LO] =
		fields.lat[pcie_cap_pkg::LAT_L1];
	assign devcap_word[pcie_cap_pkg::DC_L0S_HI:pcie_cap_pkg::DC_L0S_LO] =
		fields.lat[pcie_cap_pkg::LAT_L0S];

	// Access decode
	assign rd_sel = decode(CFG_ADDR);
	assign wr_sel = decode(CFG_ADDR);
	assign rd_hit = CFG_RD && (rd_sel != SEL_NONE);
	assign wr_hit = CFG_WR && (wr_sel != SEL_NONE);

	// Read data select; unmapped reads return zero
	always_comb begin
		next_rdata = rdata;
		if (CFG_RD) begin
			case (rd_sel)
				SEL_CAP: begin
					next_rdata = {16'h0000, cap_word};
				end
				SEL_DEVCAP: begin
					next_rdata = devcap_word;
				end
				default: begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
	end

	// Read data holds until the next read
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata <= pcie_cap_pkg::RDATA_RESET;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Acknowledge strobes; write data is dropped
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_ack <= 1'b0;
			wr_ack <= 1'b0;
			hit <= 1'b0;
		end else begin
			rd_ack <= CFG_RD;
			wr_ack <= CFG_WR;
			hit <= rd_hit || wr_hit;
		end
	end

	// Live copies of both registers for observation
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cap_q <= pcie_cap_pkg::CAP_RESET;
			devcap_q <= pcie_cap_pkg::DEVCAP_RESET;
		end else begin
			cap_q <= cap_word;
			devcap_q <= devcap_word;
		end
	end

	// Outputs straight from flip-flops
	assign CFG_RDATA = rdata;
	assign CFG_RD_ACK = rd_ack;
	assign CFG_WR_ACK = wr_ack;
	assign CFG_HIT = hit;
	assign CAP_VALUE = cap_q;
	assign DEVCAP_VALUE = devcap_q;
endmodule : pcie_capability_regs
`default_nettype wire

// file: test/pcie_capability_regs_properties.sv
// Concurrent checks on the capability register bank ports
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_regs_properties (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CFG_RD,
	input wire logic CFG_WR,
	input wire logic [7:0] CFG_ADDR,
	input wire logic MSG_SLOT_PWR_VALID,
	input wire logic [9:0] MSG_SLOT_PWR_PAYLOAD,
	input wire logic [2:0] GEN_GEN_CTRL_A,
	input wire logic [2:0] GEN_GEN_CTRL_B,
	input wire logic [2:0] PHY_L1_EXIT_LAT,
	input wire logic [2:0] PHY_L0S_EXIT_LAT,
	input wire logic [31:0] CFG_RDATA,
	input wire logic CFG_RD_ACK,
	input wire logic CFG_WR_ACK,
	input wire logic CFG_HIT,
	input wire logic [15:0] CAP_VALUE,
	input wire logic [31:0] DEVCAP_VALUE
);
	// Larger of two latency codes
	function automatic logic [2:0] mx(input logic [2:0] a, input logic [2:0] b);
		return (a > b) ? a : b;
	endfunction : mx

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_cap_fixed: assert property (CAP_VALUE == 16'h0071)
		else $error("capabilities word not constant");
	a_devcap_fixed: assert property (
		{DEVCAP_VALUE[31:28], DEVCAP_VALUE[17:12], DEVCAP_VALUE[5:0]} == 16'h0202)
		else $error("hardwired device capability bits wrong");
	a_read_devcap: assert property (
		CFG_RD && CFG_ADDR == 8'h94 |=> CFG_RD_ACK && CFG_HIT && CFG_RDATA == DEVCAP_VALUE)
		else $error("device capabilities read wrong");
	a_read_cap: assert property (
		CFG_RD && CFG_ADDR == 8'h92 |=> CFG_HIT && CFG_RDATA == 32'h00000071)
		else $error("capabilities read wrong");
	a_write_ignored: assert property (
		CFG_WR && !CFG_RD |=> CFG_WR_ACK && CFG_RDATA == $past(CFG_RDATA))
		else $error("write not acked or changed read data");
	a_msg_capture: assert property (
		MSG_SLOT_PWR_VALID |-> ##2 DEVCAP_VALUE[27:18] == $past(MSG_SLOT_PWR_PAYLOAD, 2))
		else $error("slot power payload not captured");
	a_power_hold: assert property (
		!$past(MSG_SLOT_PWR_VALID, 2) |-> $stable(DEVCAP_VALUE[27:18]))
		else $error("captured power changed without message");
	// Two clean edges needed: clamp flop, then copy flop, both out of reset
	a_l1_clamp: assert property (
		$past(RST_B, 2) && $past(RST_B) |->
		DEVCAP_VALUE[11:9] == mx($past(GEN_GEN_CTRL_A, 2), $past(PHY_L1_EXIT_LAT, 2)))
		else $error("Gen_ctrl_a field wrong");
	a_l0s_clamp: assert property (
		$past(RST_B, 2) && $past(RST_B) |->
		DEVCAP_VALUE[8:6] == mx($past(GEN_GEN_CTRL_B, 2), $past(PHY_L0S_EXIT_LAT, 2)))
		else $error("Gen_ctrl_b field wrong");

	c_message: cover property (MSG_SLOT_PWR_VALID);
	c_unmapped: cover property (CFG_RD_ACK && !CFG_HIT);
	c_write: cover property (CFG_WR_ACK && CFG_HIT);
endmodule : pcie_capability_regs_properties

bind pcie_capability_regs pcie_capability_regs_properties props (.CLK, .RST_B, .CFG_RD, .CFG_WR,
	.CFG_ADDR, .MSG_SLOT_PWR_VALID, .MSG_SLOT_PWR_PAYLOAD, .GEN_GEN_CTRL_A, .GEN_GEN_CTRL_B,
	.PHY_L1_EXIT_LAT, .PHY_L0S_EXIT_LAT, .CFG_RDATA, .CFG_RD_ACK, .CFG_WR_ACK, .CFG_HIT,
	.CAP_VALUE, .DEVCAP_VALUE);
`default_nettype wire

// file: test/root_cplx_model.sv
// Root complex model issuing configuration accesses and slot power messages
`timescale 1ns/1ps
`default_nettype none
module root_cplx_model (
	input wire logic clk,
	input wire logic rd_ack,
	input wire logic wr_ack,
	input wire logic hit,
	input wire logic [31:0] rdata,
	output logic rd,
	output logic wr,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic msg_valid,
	output logic [9:0] msg_payload
);
	// Idle bus at time zero
	initial begin
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		msg_valid = 1'b0;
		msg_payload = 10'h0;
	end

	// One-cycle request; answer taken the cycle after
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] dt,
		output logic [31:0] d, output logic h, output logic ack);
		@(posedge clk);
		#1;
		rd = !w;
		wr = w;
		addr = a;
		wdata = dt;
		@(posedge clk);
		#1;
		d = rdata;
		h = hit;
		ack = w ? wr_ack : rd_ack;
		rd = 1'b0;
		wr = 1'b0;
		addr = ~a;  // Released lines do not keep the old value
		wdata = ~dt;
	endtask : access

	// One-cycle slot power message
	task automatic send_msg(input logic [9:0] p);
		@(posedge clk);
		#1;
		msg_valid = 1'b1;
		msg_payload = p;
		@(posedge clk);
		#1;
		msg_valid = 1'b0;
		msg_payload = ~p;
	endtask : send_msg
endmodule : root_cplx_model
`default_nettype wire

// file: test/pcie_capability_regs_tb.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_regs_tb;
	logic CLK, RST_B, rd, wr, mv, rdack, wrack, hit, h, ack;
	logic [7:0] addr, a;
	logic [31:0] wd, rdata, d, dc;
	logic [9:0] pl, p;
	logic [2:0] g1, g0, f1, f0;
	logic [15:0] cap, lfsr;
	int miscompares, check_count, i;

	pcie_capability_regs dut (.CLK(CLK), .RST_B(RST_B), .CFG_RD(rd), .CFG_WR(wr), .CFG_ADDR(addr),
		.CFG_WDATA(wd), .MSG_SLOT_PWR_VALID(mv), .MSG_SLOT_PWR_PAYLOAD(pl), .GEN_GEN_CTRL_A(g1),
		.GEN_GEN_CTRL_B(g0), .PHY_L1_EXIT_LAT(f1), .PHY_L0S_EXIT_LAT(f0), .CFG_RDATA(rdata),
		.CFG_RD_ACK(rdack), .CFG_WR_ACK(wrack), .CFG_HIT(hit), .CAP_VALUE(cap), .DEVCAP_VALUE(dc));
	root_cplx_model rc (.clk(CLK), .rd_ack(rdack), .wr_ack(wrack), .hit(hit), .rdata(rdata),
		.rd(rd), .wr(wr), .addr(addr), .wdata(wd), .msg_valid(mv), .msg_payload(pl));

	// Clock at 50 MHz
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// Random source and expected values
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic [2:0] mx(input logic [2:0] x, input logic [2:0] y);
		return (x > y) ? x : y;
	endfunction : mx
	function automatic logic [31:0] exp_dc(input logic [9:0] q, input logic [2:0] l1, l0);
		return {4'h0, q, 2'h0, 4'h8, l1, l0, 6'h02};
	endfunction : exp_dc

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Access with ack and hit checked, and read data checked on reads only
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] e, input string n);
		lfsr = lfsr_next(lfsr);
		rc.access(w, ad, {lfsr, ~lfsr}, d, h, ack);
		chk({n, "_ack"}, 32'h1, {31'h0, ack});
		chk({n, "_hit"}, {31'h0, ad == 8'h92 || ad == 8'h94}, {31'h0, h});
		if (!w) chk(n, e, d);
	endtask : xfer

	// Watchdog
	initial begin
		repeat (5000) @(posedge CLK);
		miscompares++;
		end_of_test();
	end

	// Main sequence
	initial begin
		RST_B = 1'b0;
		{g1, g0, f1, f0} = 12'h000;
		lfsr = 16'h0041;
		repeat (20) @(posedge CLK);
		chk("cap_reset", 32'h0071, {16'h0, cap});
		chk("devcap_reset", 32'h00008002, dc);
		#1 RST_B = 1'b1;
		for (i = 0; i < 40; i++) begin
			lfsr = lfsr_next(lfsr);
			p = lfsr[9:0];
			if (i < 4) p[9:8] = i[1:0];
			{g1, g0, f1, f0} = lfsr[15:4];
			if (i[0]) rc.send_msg(~p);
			rc.send_msg(p);
			xfer(1'b1, i[1] ? 8'h92 : 8'h94, 32'h0, "write");
			xfer(1'b0, 8'h94, exp_dc(p, mx(g1, f1), mx(g0, f0)), "devcap");
			xfer(1'b0, 8'h92, 32'h0071, "cap");
			a = lfsr[15:8];
			if (a == 8'h92 || a == 8'h94) a = 8'h90;
			xfer(1'b0, a, 32'h0, "unmapped");
		end
		RST_B = 1'b0;
		@(posedge CLK);
		chk("devcap_reset2", 32'h00008002, dc);
		#1 RST_B = 1'b1;
		xfer(1'b0, 8'h94, exp_dc(10'h0, mx(g1, f1), mx(g0, f0)), "devcap_clear");
		end_of_test();
	end
endmodule : pcie_capability_regs_tb
`default_nettype wire
